// >>> sim/event_source.sv
`timescale 1ns/1ps
// external event pulses, each level held well past the minimum width
module event_source (
  input wire logic clk,
  output logic     eventInputPin
);
  initial eventInputPin = 1'b0;
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      @(posedge clk);
      eventInputPin <= 1'b1;
      repeat (w) @(posedge clk);
      eventInputPin <= 1'b0;
      repeat (w - 1) @(posedge clk);
    end
  endtask
endmodule

// >>> sim/timer_counter_8bit_tb.sv
`timescale 1ns/1ps
module timer_counter_8bit_tb;
  logic [timer_counter_pkg::ADDR_WIDTH-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]                              s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]                               s_axi_bresp, s_axi_rresp, rs;
  logic                                     clk, rst_b, stopModeEntry, eventInputPin, k;
  logic                                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                                     s_axi_rvalid, s_axi_rready;
  logic                                     timerInterrupt, dividerOutputPin, pwmOutputPin;
  int                                       fails, cmp_count, cyc, irqs, t0, t1, n, c, s, ctrlM, preM;
  int                                       expo[7] = '{11, 7, 5, 3, 2, 1, 0};
  timer_counter_8bit timer_counter_8bit_inst (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .stopModeEntry(stopModeEntry), .eventInputPin(eventInputPin),
    .timerInterrupt(timerInterrupt), .dividerOutputPin(dividerOutputPin), .pwmOutputPin(pwmOutputPin));
  event_source event_source_inst (.clk(clk), .eventInputPin(eventInputPin));
  // clock and cycle bookkeeping
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (timerInterrupt === 1'b1) irqs <= irqs + 1;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----
  // bus master
  // ----
  task wr(input logic [timer_counter_pkg::ADDR_WIDTH-1:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      // ready raised late so the response must stand a cycle
      s_axi_bready <= (s_axi_bvalid === 1'b1) && (s_axi_bready !== 1'b1);
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    rs = s_axi_bresp;
  endtask
  task rdReg(input logic [timer_counter_pkg::ADDR_WIDTH-1:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= (s_axi_rvalid === 1'b1) && (s_axi_rready !== 1'b1);
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // ----
  // register model
  // ----
  task wrM(input logic [timer_counter_pkg::ADDR_WIDTH-1:0] a, input logic [31:0] d);
    wr(a, d);
    if (a == timer_counter_pkg::CONTROL_ADDR) ctrlM = d[5:0];
    if (a == timer_counter_pkg::POWER_ADDR) preM = d[0];
    check(rs, timer_counter_pkg::RESP_OKAY);
  endtask
  task chkReg(input logic [timer_counter_pkg::ADDR_WIDTH-1:0] a, input logic [31:0] exp);
    rdReg(a);
    check(rd, exp);
    check(rs, timer_counter_pkg::RESP_OKAY);
  endtask
  task start(input int m, input int src, input int v);
    wrM(timer_counter_pkg::CONTROL_ADDR, (src << 2) | m);
    wrM(timer_counter_pkg::COMPARE_ADDR, v);
    wrM(timer_counter_pkg::CONTROL_ADDR, ctrlM | 32'h20);
  endtask
  task nextIrq(output int t);
    do @(posedge clk);
    while (timerInterrupt !== 1'b1);
    t = cyc;
  endtask
  task lowCount(output int lows, output int t);
    lows = 0;
    do begin
      @(posedge clk);
      if (pwmOutputPin === 1'b0) lows++;
    end while (timerInterrupt !== 1'b1);
    t = cyc;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, stopModeEntry, rst_b} = '0;
    {fails, cmp_count, cyc, irqs, ctrlM, preM} = '0;
    void'($urandom(32'he70ddb8e));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    chkReg(timer_counter_pkg::CONTROL_ADDR, 32'h00);
    chkReg(timer_counter_pkg::COMPARE_ADDR, 32'hff);
    rdReg(10'h000);
    check(rs, timer_counter_pkg::RESP_SLVERR);
    wr(10'h3fc, 32'h1);
    check(rs, timer_counter_pkg::RESP_SLVERR);
    wrM(timer_counter_pkg::CONTROL_ADDR, 32'hde);
    chkReg(timer_counter_pkg::CONTROL_ADDR, 32'h1e);
    for (int i = 0; i < 3; i++) begin
      c = 1 + $urandom % 6;
      s = 1 + $urandom % 3;
      wrM(timer_counter_pkg::POWER_ADDR, $urandom % 2);
      start(0, s, c);
      nextIrq(t0);
      nextIrq(t1);
      check(t1 - t0, (c + 1) << (expo[s] + preM));
      wrM(timer_counter_pkg::CONTROL_ADDR, ctrlM & 32'h1f);
      chkReg(timer_counter_pkg::POWER_ADDR, preM);
    end
    wrM(timer_counter_pkg::POWER_ADDR, 0);
    start(2, 2, 2);
    nextIrq(t0);
    repeat (2) @(posedge clk);
    k = dividerOutputPin;
    nextIrq(t1);
    repeat (2) @(posedge clk);
    check(t1 - t0, 3 << expo[2]);
    check(dividerOutputPin, {31'h0, ~k});
    stopModeEntry <= 1'b1;
    repeat (6) @(posedge clk);
    stopModeEntry <= 1'b0;
    chkReg(timer_counter_pkg::CONTROL_ADDR, ctrlM & 32'h1f);
    check({dividerOutputPin, pwmOutputPin}, 2'b11);
    start(0, 7, 3);
    n = irqs;
    event_source_inst.pulse(7, 8);
    repeat (4) @(posedge clk);
    check(irqs - n, 2);
    wrM(timer_counter_pkg::CONTROL_ADDR, ctrlM & 32'h1f);
    start(3, 5, 32'h40);
    lowCount(n, t0);
    check(n, (256 - 32'h40) * 2);
    wrM(timer_counter_pkg::COMPARE_ADDR, 32'hc0);
    lowCount(n, t1);
    check(n, (256 - 32'h40) * 2);
    lowCount(n, t1);
    check(n, (256 - 32'hc0) * 2);
    check(t1 - t0, 2 * 256 * 2);
    wrM(timer_counter_pkg::CONTROL_ADDR, ctrlM & 32'h1f);
    repeat (3) @(posedge clk);
    check(pwmOutputPin, 1'b1);
    summarize();
  end
  // hang guard
  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule

// >>> sim/timer_counter_props.sv
`timescale 1ns/1ps
// ----
// bus and pin checks
// ----
module timer_counter_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        stopModeEntry,
  input wire logic        timerInterrupt,
  input wire logic        dividerOutputPin,
  input wire logic        pwmOutputPin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // handshake and stop-mode steps
  sequence wrTaken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence stopHeld;
    stopModeEntry [*4];
  endsequence
  a_write_answer: assert property ((s_axi_awvalid && s_axi_awready) ##0 wrTaken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bvalid_cause: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wvalid && s_axi_wready, 2)
    || $past(s_axi_awvalid && s_axi_awready, 2)) else $error("write response without request");
  a_rvalid_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read data without request");
  a_irq_single_pulse: assert property (timerInterrupt |=> !timerInterrupt)
    else $error("interrupt longer than one cycle");
  a_stop_quiet: assert property (stopHeld |-> !timerInterrupt && dividerOutputPin && pwmOutputPin)
    else $error("timer still active in stop mode");
  a_div_fall_irq: assert property ($fell(dividerOutputPin) |-> ##[0:1] (timerInterrupt || $past(timerInterrupt)))
    else $error("divider toggle without interrupt");
endmodule

bind timer_counter_8bit timer_counter_props timer_counter_props_inst (.clk(clk), .rst_b(rst_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .stopModeEntry(stopModeEntry), .timerInterrupt(timerInterrupt),
  .dividerOutputPin(dividerOutputPin), .pwmOutputPin(pwmOutputPin));

// >>> src/source_clock_select.sv
`timescale 1ns/1ps
// one-cycle count enable from the prescaler or the event pin
module source_clock_select (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       running,
  input  wire logic [2:0] sourceClock,
  input  wire logic       prescaleSelect,
  input  wire logic       eventInput,
  output logic            countTick,
  output logic            eventRise,
  output logic            eventFall
);

  logic [timer_counter_pkg::DIVIDER_WIDTH-1:0] divider;
  logic [timer_counter_pkg::DIVIDER_WIDTH-1:0] next_divider;
  logic                                        eventLast;
  logic [3:0]                                  tapIndex;

  // exponent of the division per code
  function automatic logic [3:0] tap_for(input logic [2:0] code, input logic pre);
    logic [3:0] base;
    base = 4'h0;
    case (code)
      3'b000:  base = 4'hb;
      3'b001:  base = 4'h7;
      3'b010:  base = 4'h5;
      3'b011:  base = 4'h3;
      3'b100:  base = 4'h2;
      3'b101:  base = 4'h1;
      default: base = 4'h0;
    endcase
    return base + {3'h0, pre};
  endfunction

  assign tapIndex     = tap_for(sourceClock, prescaleSelect);
  assign next_divider = divider + 13'h0001;

  // free-running divider, restarted while stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divider <= '0;
    end else if (!running) begin
      divider <= '0;
    end else begin
      divider <= next_divider;
    end
  end

  // event pin edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eventLast <= 1'b0;
    end else begin
      eventLast <= eventInput;
    end
  end

  assign eventRise = eventInput & ~eventLast;
  assign eventFall = ~eventInput & eventLast;

  // tick when the low tap bits roll over
  always_comb begin
    if (sourceClock == timer_counter_pkg::CLOCK_EXTERNAL) begin
      countTick = running & eventRise;
    end else if (tapIndex == 4'h0) begin
      countTick = running;
    end else begin
      countTick = running &
                  ((next_divider & ((13'h0001 << tapIndex) - 13'h0001)) == 13'h0000);
    end
  end

endmodule

// >>> src/timer_counter_8bit.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module timer_counter_8bit (
  input  wire logic                                     clk,
  input  wire logic                                     rst_b,
  // axi4-lite slave
  input  wire logic [timer_counter_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                                     s_axi_awvalid,
  output logic                                          s_axi_awready,
  input  wire logic [31:0]                              s_axi_wdata,
  input  wire logic [3:0]                               s_axi_wstrb,
  input  wire logic                                     s_axi_wvalid,
  output logic                                          s_axi_wready,
  output logic [1:0]                                    s_axi_bresp,
  output logic                                          s_axi_bvalid,
  input  wire logic                                     s_axi_bready,
  input  wire logic [timer_counter_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                                     s_axi_arvalid,
  output logic                                          s_axi_arready,
  output logic [31:0]                                   s_axi_rdata,
  output logic [1:0]                                    s_axi_rresp,
  output logic                                          s_axi_rvalid,
  input  wire logic                                     s_axi_rready,
  // device side
  input  wire logic                                     stopModeEntry,
  input  wire logic                                     eventInputPin,
  output logic                                          timerInterrupt,
  output logic                                          dividerOutputPin,
  output logic                                          pwmOutputPin
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  timer_counter_pkg::control_t control;
  logic [7:0]                  compareValue;
  logic [7:0]                  shadowCompare;
  logic [7:0]                  upCounter;
  logic                        prescaleSelect;
  logic                        countTick;
  logic                        eventRise;
  logic                        eventFall;
  logic                        eventMatchPending;
  logic                        running;
  logic                        isEvent;
  logic                        matchNow;
  logic                        startPulse;
  logic                        tickMatch;
  logic                        tickOverflow;

  // axi bookkeeping
  logic [timer_counter_pkg::ADDR_WIDTH-1:0] writeAddr;
  logic [31:0]                              writeData;
  logic [3:0]                               writeStrb;
  logic                                     haveAddr;
  logic                                     haveData;
  logic                                     doWrite;
  logic                                     ctrlWrite;
  logic                                     compWrite;
  logic                                     powerWrite;

  assign running  = control.run;
  assign isEvent  = (control.sourceClock == timer_counter_pkg::CLOCK_EXTERNAL);
  assign matchNow = (upCounter == compareValue);

  // ----------------------------------------
  // register write path
  // ----------------------------------------
  // address and data captured in either order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      haveAddr      <= 1'b0;
      haveData      <= 1'b0;
      writeAddr     <= '0;
      writeData     <= '0;
      writeStrb     <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= timer_counter_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !haveAddr && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !haveData && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        haveAddr  <= 1'b1;
        writeAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveData  <= 1'b1;
        writeData <= s_axi_wdata;
        writeStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        haveAddr     <= 1'b0;
        haveData     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (ctrlWrite || compWrite || powerWrite ||
                         writeAddr == timer_counter_pkg::CONTROL_ADDR ||
                         writeAddr == timer_counter_pkg::COMPARE_ADDR ||
                         writeAddr == timer_counter_pkg::POWER_ADDR) ?
                        timer_counter_pkg::RESP_OKAY : timer_counter_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign doWrite    = haveAddr && haveData && !s_axi_bvalid;
  assign ctrlWrite  = doWrite && writeStrb[0] && (writeAddr == timer_counter_pkg::CONTROL_ADDR);
  assign compWrite  = doWrite && writeStrb[0] && (writeAddr == timer_counter_pkg::COMPARE_ADDR);
  assign powerWrite = doWrite && writeStrb[0] && (writeAddr == timer_counter_pkg::POWER_ADDR);
  assign startPulse = ctrlWrite && writeData[timer_counter_pkg::RUN_BIT] && !control.run;

  // control register; stop-mode entry wins over a write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control <= timer_counter_pkg::control_t'(timer_counter_pkg::CONTROL_RESET);
    end else begin
      if (ctrlWrite) begin
        control <= timer_counter_pkg::control_t'(writeData[5:0]);
      end
      if (stopModeEntry) begin
        control.run <= 1'b0;
      end
    end
  end

  // compare value and prescale select
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compareValue   <= timer_counter_pkg::COMPARE_RESET;
      prescaleSelect <= 1'b0;
    end else begin
      if (compWrite) begin
        compareValue <= writeData[7:0];
      end
      if (powerWrite) begin
        prescaleSelect <= writeData[timer_counter_pkg::PRESCALE_BIT];
      end
    end
  end

  // ----------------------------------------
  // register read path
  // ----------------------------------------
  // single read outstanding, answered one cycle after acceptance
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= timer_counter_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= timer_counter_pkg::RESP_OKAY;
        case (s_axi_araddr)
          timer_counter_pkg::CONTROL_ADDR: s_axi_rdata <= {26'h0, control};
          timer_counter_pkg::COMPARE_ADDR: s_axi_rdata <= {24'h0, compareValue};
          timer_counter_pkg::POWER_ADDR:   s_axi_rdata <= {23'h0, upCounter, prescaleSelect};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= timer_counter_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // count source
  // ----------------------------------------
  source_clock_select source_clock_select_inst (
    .clk            (clk),
    .rst_b          (rst_b),
    .running        (running),
    .sourceClock    (control.sourceClock),
    .prescaleSelect (prescaleSelect),
    .eventInput     (eventInputPin),
    .countTick      (countTick),
    .eventRise      (eventRise),
    .eventFall      (eventFall)
  );

  assign tickMatch    = countTick && !isEvent && matchNow;
  assign tickOverflow = countTick && (upCounter == 8'hff);

  // ----------------------------------------
  // up-counter
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upCounter         <= '0;
      eventMatchPending <= 1'b0;
    end else if (!running) begin
      upCounter         <= '0;
      eventMatchPending <= 1'b0;
    end else begin
      case (control.mode)
        timer_counter_pkg::MODE_TIMER: begin
          if (isEvent) begin
            if (eventFall && matchNow) begin
              upCounter <= '0;
            end else if (countTick) begin
              upCounter <= upCounter + 8'h01;
            end
          end else if (tickMatch) begin
            upCounter <= '0;
          end else if (countTick) begin
            upCounter <= upCounter + 8'h01;
          end
        end
        timer_counter_pkg::MODE_DIVIDER: begin
          if (tickMatch) begin
            upCounter <= '0;
          end else if (countTick) begin
            upCounter <= upCounter + 8'h01;
          end
        end
        timer_counter_pkg::MODE_PWM: begin
          if (countTick) begin
            upCounter <= upCounter + 8'h01;
          end
        end
        default: upCounter <= upCounter;
      endcase
    end
  end

  // pwm shadow compare
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shadowCompare <= timer_counter_pkg::COMPARE_RESET;
    end else if (startPulse) begin
      shadowCompare <= compWrite ? writeData[7:0] : compareValue;
    end else if (running && tickOverflow) begin
      shadowCompare <= compareValue;
    end
  end

  // ----------------------------------------
  // outputs and interrupt
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dividerOutputPin <= 1'b1;
      pwmOutputPin     <= 1'b1;
      timerInterrupt   <= 1'b0;
    end else if (!running) begin
      dividerOutputPin <= 1'b1;
      pwmOutputPin     <= 1'b1;
      timerInterrupt   <= 1'b0;
    end else begin
      timerInterrupt <= 1'b0;
      case (control.mode)
        timer_counter_pkg::MODE_TIMER: begin
          if (isEvent) begin
            timerInterrupt <= eventFall && matchNow;
          end else begin
            timerInterrupt <= tickMatch;
          end
        end
        timer_counter_pkg::MODE_DIVIDER: begin
          if (tickMatch) begin
            dividerOutputPin <= ~dividerOutputPin;
            timerInterrupt   <= 1'b1;
          end
        end
        timer_counter_pkg::MODE_PWM: begin
          if (tickOverflow) begin
            pwmOutputPin   <= 1'b1;
            timerInterrupt <= 1'b1;
          end else if (countTick && (upCounter + 8'h01 == shadowCompare)) begin
            pwmOutputPin <= 1'b0;
          end
        end
        default: timerInterrupt <= 1'b0;
      endcase
    end
  end

endmodule

// >>> src/timer_counter_pkg.sv
package timer_counter_pkg;

  // ----------------------------------------
  // register map (printed offsets are not multiples of four: index * 4)
  // ----------------------------------------
  localparam logic [7:0] CONTROL_INDEX        = 8'h1a;
  localparam logic [7:0] COMPARE_INDEX        = 8'h1b;
  localparam logic [7:0] POWER_INDEX          = 8'h1c;
  localparam logic [9:0] CONTROL_ADDR         = {CONTROL_INDEX, 2'b00};
  localparam logic [9:0] COMPARE_ADDR         = {COMPARE_INDEX, 2'b00};
  localparam logic [9:0] POWER_ADDR           = {POWER_INDEX, 2'b00};
  localparam int         ADDR_WIDTH           = 10;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int         MODE_LSB             = 0;
  localparam int         CLOCK_LSB            = 2;
  localparam int         RUN_BIT              = 5;
  localparam int         PRESCALE_BIT         = 0;
  localparam int         STOP_ENTRY_BIT       = 1;
  localparam logic [5:0] CONTROL_RESET        = 6'h00;
  localparam logic [7:0] COMPARE_RESET        = 8'hff;
  localparam logic [1:0] RESP_OKAY            = 2'b00;
  localparam logic [1:0] RESP_SLVERR          = 2'b10;

  // ----------------------------------------
  // external source clock code and divider width
  // ----------------------------------------
  localparam logic [2:0] CLOCK_EXTERNAL       = 3'b111;
  localparam int         DIVIDER_WIDTH        = 13;

  typedef enum logic [1:0] {
    MODE_TIMER    = 2'b00,
    MODE_RESERVED = 2'b01,
    MODE_DIVIDER  = 2'b10,
    MODE_PWM      = 2'b11
  } mode_t;

  typedef struct packed {
    logic       run;
    logic [2:0] sourceClock;
    mode_t      mode;
  } control_t;

endpackage
